// ---- verilog/pdma_pkg.sv ----
/*
  Shared constants for the peripheral DMA channel: register offsets,
  field positions, reset values, event bits, bus encodings and states.
  Assumes a 32-bit byte-addressed system bus with 32-bit data.
*/
package pdma_pkg;

  // Register offsets
  localparam logic [7:0] OFS_TASK   = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_BUF_POINTER = 8'h08;
  localparam logic [7:0] OFS_MAX_COUNT   = 8'h0c;
  localparam logic [7:0] OFS_XFER_COUNT  = 8'h10;
  localparam logic [7:0] OFS_LIST   = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_INTCLR = 8'h1c;
  localparam logic [7:0] OFS_INTEN  = 8'h20;
  localparam logic [7:0] OFS_STATE  = 8'h24;

  // Field positions
  localparam int TASK_START = 0;
  localparam int TASK_STOP  = 1;
  localparam int CFG_DIR    = 0;
  localparam int CFG_DROP   = 1;
  localparam int ST_BUSY    = 0;
  localparam int ST_ITEM    = 16;

  // Event bits
  localparam int EV_W    = 3;
  localparam int EV_END  = 0;
  localparam int EV_ERR  = 1;
  localparam int EV_DROP = 2;

  // Reset values
  localparam logic [31:0] RST_BUF_POINTER = 32'h0000_0000;
  localparam logic [1:0]  RST_CFG = 2'h0;

  // Bus encodings
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE    = 3'h0;
  localparam logic [1:0] HRESP_OKAY    = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_FETCH   = 3'b001,
    ST_ADDR    = 3'b010,
    ST_DATA    = 3'b011,
    ST_DELIVER = 3'b100
  } pdma_state_e;

endpackage

// ---- verilog/pdma_irq.sv ----
/*
  Sticky event status, enable register and level interrupt output.
  Assumes event pulses and register strobes on the same clock.
*/
module pdma_irq (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Events and software access
  input  wire logic [pdma_pkg::EV_W-1:0] ev,
  input  wire logic                     clr_we,
  input  wire logic                     en_we,
  input  wire logic [pdma_pkg::EV_W-1:0] wdata,
  // State
  output logic      [pdma_pkg::EV_W-1:0] status,
  output logic      [pdma_pkg::EV_W-1:0] enable,
  output logic                          irq
);

  // Set wins over clear so an event in the clear cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else if (clr_we) begin
      status <= (status & ~wdata) | ev;
    end else begin
      status <= status | ev;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable <= '0;
    end else if (en_we) begin
      enable <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & enable);
    end
  end

  // R17: end event latched
  end_sticky_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
    ev[pdma_pkg::EV_END] |=> status[pdma_pkg::EV_END])
    else $error("end event not latched in status");

endmodule

// ---- verilog/pdma_channel.sv ----
/*
  One peripheral DMA channel: a byte-wide bus master that moves data
  between data RAM and its peripheral, with register port and interrupt.
  Assumes a bus with request/grant arbitration and byte lanes selected
  by the low address bits; peripheral streams run on the same clock.
*/
// Decided for this implementation: the register addresses and the address-and-strobe port.
//Contract
//R01: Acts as bus master without CPU
//R02: Never accesses outside data RAM
//R03: Each instance serves one direction; here CONFIG bit 0 picks the direction for each transfer
//R04: Read channel fetches exactly max count
//R05: Write channel stores at most max count
//R06: Byte-granular pointers, consecutive byte addresses
//R07: Software keeps write count within buffer
//R08: Transferred count readable after completion
//R09: Software loads valid pointer before start
//R10: Bad pointer or bus error is error
//R11: Wait for grant; stall or drop input
//R12: List mode only with list register
//R13: List items lie back to back
//R14: Item size equals max count
//R15: Each item advances start by count
//R16: Start needs pointer, count; latches both
//R17: End event when transfer finished
module pdma_channel #(
  parameter int          CNT_W    = 16,
  parameter bit          HAS_LIST = 1'b1,
  parameter logic [31:0] RAM_BASE = 32'h2000_0000,
  parameter logic [31:0] RAM_SIZE = 32'h0004_0000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  // System bus master
  output logic             hbusreq,
  input  wire logic        hgrant,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [1:0]  hresp,
  input  wire logic [31:0] hrdata,
  // Peripheral byte streams
  output logic             out_valid,
  output logic      [7:0]  out_data,
  input  wire logic        out_ready,
  input  wire logic        in_valid,
  input  wire logic [7:0]  in_data,
  input  wire logic        in_last,
  output logic             in_ready,
  output logic             busy
);

  pdma_pkg::pdma_state_e state;

  logic [1:0]       cfg;
  logic             list_mode;
  logic [31:0]      buffer_pointer;
  logic [CNT_W-1:0] max_byte_count;
  logic             pointer_set;
  logic             cnt_set;
  logic [CNT_W-1:0] item_idx;
  logic [CNT_W-1:0] transferred_count;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] lat_len;
  logic             lat_dir;
  logic             lat_list;
  logic             last_pend;
  logic             stop_pend;
  logic [pdma_pkg::EV_W-1:0] ev;
  logic [pdma_pkg::EV_W-1:0] ev_status;
  logic [pdma_pkg::EV_W-1:0] ev_enable;

  logic        wr_task;
  logic        start_req;
  logic        stop_req;
  logic [31:0] eff_addr;
  logic [CNT_W-1:0] count_inc;
  logic        beat_ok;
  logic        beat_err;

  // Whole transfer must sit inside data RAM
  function automatic logic in_ram(input logic [31:0] a, input logic [CNT_W-1:0] n);
    logic [32:0] last_end;
    logic [32:0] ram_end;
    last_end = {1'b0, a} + 33'(n);
    ram_end  = {1'b0, RAM_BASE} + {1'b0, RAM_SIZE};
    return (a >= RAM_BASE) && (last_end <= ram_end);
  endfunction

  // Pick the byte lane that the address selects
  function automatic logic [7:0] lane(input logic [31:0] w, input logic [1:0] sel);
    return w[8*sel +: 8];
  endfunction

  assign wr_task   = reg_wr && (reg_addr == pdma_pkg::OFS_TASK);
  assign start_req = wr_task && reg_wdata[pdma_pkg::TASK_START];
  assign stop_req  = wr_task && reg_wdata[pdma_pkg::TASK_STOP];
  // R13: list items back to back
  // R15: item k starts k counts on
  assign eff_addr  = buffer_pointer + 32'(32'(item_idx) * 32'(max_byte_count));
  assign count_inc = count + CNT_W'(1);
  assign beat_ok   = (state == pdma_pkg::ST_DATA) && hready && (hresp == pdma_pkg::HRESP_OKAY);
  assign beat_err  = (state == pdma_pkg::ST_DATA) && hready && (hresp != pdma_pkg::HRESP_OKAY);

  // Configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= pdma_pkg::RST_CFG;
    end else if (reg_wr && reg_addr == pdma_pkg::OFS_CONFIG) begin
      cfg <= reg_wdata[1:0];
    end
  end

  // R12: list select only when present
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      list_mode <= 1'b0;
    end else if (reg_wr && reg_addr == pdma_pkg::OFS_LIST) begin
      list_mode <= HAS_LIST & reg_wdata[0];
    end
  end

  // R09: pointer must be loaded first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_pointer <= pdma_pkg::RST_BUF_POINTER;
      pointer_set    <= 1'b0;
    end else if (reg_wr && reg_addr == pdma_pkg::OFS_BUF_POINTER) begin
      buffer_pointer <= reg_wdata;
      pointer_set    <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      max_byte_count <= '0;
      cnt_set        <= 1'b0;
    end else if (reg_wr && reg_addr == pdma_pkg::OFS_MAX_COUNT) begin
      max_byte_count <= reg_wdata[CNT_W-1:0];
      cnt_set        <= 1'b1;
    end
  end

  // R15: advance item after each completed list item
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      item_idx <= '0;
    end else if (reg_wr && reg_addr == pdma_pkg::OFS_BUF_POINTER) begin
      item_idx <= '0;
    end else if (ev[pdma_pkg::EV_END] && lat_list) begin
      item_idx <= item_idx + CNT_W'(1);
    end
  end

  // Stop only shortens a write transfer; a read ignores stop and runs to its count unless a bus error aborts it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_pend <= 1'b0;
    end else if (state == pdma_pkg::ST_IDLE) begin
      stop_pend <= 1'b0;
    end else if (stop_req && lat_dir) begin
      stop_pend <= 1'b1;
    end
  end

  // R01: transfer engine, bus master
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state             <= pdma_pkg::ST_IDLE;
      hbusreq           <= 1'b0;
      haddr             <= '0;
      htrans            <= pdma_pkg::HTRANS_IDLE;
      hwrite            <= 1'b0;
      hsize             <= pdma_pkg::HSIZE_BYTE;
      hwdata            <= '0;
      out_valid         <= 1'b0;
      out_data          <= '0;
      in_ready          <= 1'b0;
      busy              <= 1'b0;
      count             <= '0;
      lat_len           <= '0;
      lat_dir           <= 1'b0;
      lat_list          <= 1'b0;
      last_pend         <= 1'b0;
      transferred_count <= '0;
      ev[pdma_pkg::EV_END] <= 1'b0;
      ev[pdma_pkg::EV_ERR] <= 1'b0;
      ev[pdma_pkg::EV_DROP] <= 1'b0;
    end else begin
      ev[pdma_pkg::EV_END] <= 1'b0;
      ev[pdma_pkg::EV_ERR] <= 1'b0;
      // R11: drop-mode byte taken off the bus wait is lost
      ev[pdma_pkg::EV_DROP] <= in_valid && in_ready && (state != pdma_pkg::ST_FETCH);
      // R11: drop mode keeps the input open
      in_ready <= cfg[pdma_pkg::CFG_DROP];
      case (state)
        pdma_pkg::ST_IDLE: begin
          // R16: start only once both are set; latch them
          if (start_req && pointer_set && cnt_set) begin
            count     <= '0;
            last_pend <= 1'b0;
            if (max_byte_count == '0) begin
              transferred_count    <= '0;
              ev[pdma_pkg::EV_END] <= 1'b1;
            // R02: refuse anything outside data RAM
            // R10: bad pointer reports an error
            end else if (!in_ram(eff_addr, max_byte_count)) begin
              transferred_count    <= '0;
              ev[pdma_pkg::EV_ERR] <= 1'b1;
            end else begin
              busy     <= 1'b1;
              haddr    <= eff_addr;
              lat_len  <= max_byte_count;
              lat_dir  <= cfg[pdma_pkg::CFG_DIR];
              lat_list <= list_mode;
              hwrite   <= cfg[pdma_pkg::CFG_DIR];
              if (cfg[pdma_pkg::CFG_DIR]) begin
                state    <= pdma_pkg::ST_FETCH;
                in_ready <= 1'b1;
              end else begin
                state   <= pdma_pkg::ST_ADDR;
                hbusreq <= 1'b1;
                htrans  <= pdma_pkg::HTRANS_NONSEQ;
              end
            end
          end
        end
        pdma_pkg::ST_FETCH: begin
          // R05: write channel may end early
          if (stop_pend || stop_req) begin
            state                <= pdma_pkg::ST_IDLE;
            busy                 <= 1'b0;
            transferred_count    <= count;
            ev[pdma_pkg::EV_END] <= 1'b1;
          end else if (in_valid && in_ready) begin
            hwdata    <= {4{in_data}};
            last_pend <= in_last;
            state     <= pdma_pkg::ST_ADDR;
            hbusreq   <= 1'b1;
            htrans    <= pdma_pkg::HTRANS_NONSEQ;
          end else begin
            in_ready <= 1'b1;
          end
        end
        pdma_pkg::ST_ADDR: begin
          // R11: hold the request until granted
          if (hgrant && hready) begin
            state   <= pdma_pkg::ST_DATA;
            hbusreq <= 1'b0;
            htrans  <= pdma_pkg::HTRANS_IDLE;
          end
        end
        pdma_pkg::ST_DATA: begin
          if (beat_err) begin
            state                <= pdma_pkg::ST_IDLE;
            busy                 <= 1'b0;
            transferred_count    <= count;
            ev[pdma_pkg::EV_ERR] <= 1'b1;
            ev[pdma_pkg::EV_END] <= 1'b1;
          end else if (beat_ok) begin
            // R06: next byte address, no alignment
            count <= count_inc;
            haddr <= haddr + 32'h0000_0001;
            if (!lat_dir) begin
              out_data  <= lane(hrdata, haddr[1:0]);
              out_valid <= 1'b1;
              state     <= pdma_pkg::ST_DELIVER;
            // R05: stop at count, last byte or stop
            end else if (count_inc == lat_len || last_pend || stop_pend) begin
              state                <= pdma_pkg::ST_IDLE;
              busy                 <= 1'b0;
              transferred_count    <= count_inc;
              ev[pdma_pkg::EV_END] <= 1'b1;
            end else begin
              state    <= pdma_pkg::ST_FETCH;
              in_ready <= 1'b1;
            end
          end
        end
        pdma_pkg::ST_DELIVER: begin
          // R04: read runs to exactly the count
          if (out_ready) begin
            out_valid <= 1'b0;
            if (count == lat_len) begin
              state                <= pdma_pkg::ST_IDLE;
              busy                 <= 1'b0;
              transferred_count    <= count;
              ev[pdma_pkg::EV_END] <= 1'b1;
            end else begin
              state   <= pdma_pkg::ST_ADDR;
              hbusreq <= 1'b1;
              htrans  <= pdma_pkg::HTRANS_NONSEQ;
            end
          end
        end
        default: begin
          state <= pdma_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == pdma_pkg::OFS_CONFIG) begin
        reg_rdata <= 32'(cfg);
      end else if (reg_addr == pdma_pkg::OFS_BUF_POINTER) begin
        reg_rdata <= buffer_pointer;
      end else if (reg_addr == pdma_pkg::OFS_MAX_COUNT) begin
        reg_rdata <= 32'(max_byte_count);
      // R08: bytes moved by the last transfer
      end else if (reg_addr == pdma_pkg::OFS_XFER_COUNT) begin
        reg_rdata <= 32'(transferred_count);
      end else if (reg_addr == pdma_pkg::OFS_LIST) begin
        reg_rdata <= 32'(list_mode);
      end else if (reg_addr == pdma_pkg::OFS_STATUS) begin
        reg_rdata <= 32'(ev_status);
      end else if (reg_addr == pdma_pkg::OFS_INTEN) begin
        reg_rdata <= 32'(ev_enable);
      end else if (reg_addr == pdma_pkg::OFS_STATE) begin
        reg_rdata <= (32'(item_idx) << pdma_pkg::ST_ITEM) | 32'(busy);
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

  // R17: end, error and drop events to interrupt logic
  pdma_irq u_irq (
    .clk    (clk),
    .rst_n  (rst_n),
    .ev     (ev),
    .clr_we (reg_wr && reg_addr == pdma_pkg::OFS_INTCLR),
    .en_we  (reg_wr && reg_addr == pdma_pkg::OFS_INTEN),
    .wdata  (reg_wdata[pdma_pkg::EV_W-1:0]),
    .status (ev_status),
    .enable (ev_enable),
    .irq    (irq)
  );

  grant_wait_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
    (state == pdma_pkg::ST_ADDR && !(hgrant && hready))
    |=> (state == pdma_pkg::ST_ADDR && htrans == pdma_pkg::HTRANS_NONSEQ && hbusreq))
    else $error("address phase left without grant");

  ram_only_a: assert property (@(posedge clk) disable iff (!rst_n) // R02
    htrans == pdma_pkg::HTRANS_NONSEQ
    |-> (haddr >= RAM_BASE && {1'b0, haddr} < {1'b0, RAM_BASE} + {1'b0, RAM_SIZE}))
    else $error("access outside data RAM");

  read_exact_a: assert property (@(posedge clk) disable iff (!rst_n) // R04
    (ev[pdma_pkg::EV_END] && !ev[pdma_pkg::EV_ERR] && !lat_dir && $past(busy))
    |-> transferred_count == lat_len)
    else $error("read channel did not move exactly the count");

  write_max_a: assert property (@(posedge clk) disable iff (!rst_n) // R05
    ev[pdma_pkg::EV_END] && $past(busy) |-> transferred_count <= lat_len)
    else $error("transfer moved more than the count");

  byte_step_a: assert property (@(posedge clk) disable iff (!rst_n) // R06
    beat_ok |=> haddr == $past(haddr) + 32'h0000_0001 && count == $past(count) + CNT_W'(1))
    else $error("address did not step by one byte");

  start_latch_a: assert property (@(posedge clk) disable iff (!rst_n) // R16
    $rose(busy) |-> ($past(pointer_set) && $past(cnt_set) && lat_len == $past(max_byte_count)))
    else $error("start without pointer and count");

  list_step_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
    (ev[pdma_pkg::EV_END] && lat_list && !(reg_wr && reg_addr == pdma_pkg::OFS_BUF_POINTER))
    |=> item_idx == $past(item_idx) + CNT_W'(1))
    else $error("list item index did not advance");

  error_abort_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    beat_err |=> (ev[pdma_pkg::EV_ERR] && state == pdma_pkg::ST_IDLE && !busy))
    else $error("bus error did not abort the transfer");

  one_dir_a: assert property (@(posedge clk) disable iff (!rst_n) // R03
    htrans == pdma_pkg::HTRANS_NONSEQ |-> hwrite == lat_dir)
    else $error("bus direction differs from channel direction");

endmodule

// ---- sim/pdma_ram_model.sv ----
/*
  Behavioural data RAM slave behind the bus interconnect: delays the
  grant, inserts wait states and injects error responses on request.
  Assumes a non-pipelined byte master; memory is indexed by haddr[7:0].
*/
module pdma_ram_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Test controls
  input  wire logic        slow,
  input  wire logic        err_on,
  // Bus slave side
  input  wire logic        hbusreq,
  output logic             hgrant,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  output logic             hready,
  output logic      [1:0]  hresp,
  output logic      [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [256];
  logic       dph;
  logic       wr_q;
  logic [7:0] a_q;
  logic [1:0] wcnt;
  logic [7:0] junk;
  logic       tog;

  assign hgrant = hbusreq && !(slow && tog);
  assign hready = !(dph && wcnt != 2'h0);
  assign hresp  = (dph && hready && err_on) ? 2'h1 : 2'h0;
  // Idle data lines churn so a stale sample never matches
  assign hrdata = dph ? {4{mem[a_q]}} : {4{junk}};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dph  <= 1'b0;
      wcnt <= 2'h0;
      tog  <= 1'b0;
      junk <= 8'h5a;
    end else begin
      tog  <= !tog;
      junk <= junk + 8'h3b;
      if (dph) begin
        if (wcnt != 2'h0) begin
          wcnt <= wcnt - 2'h1;
        end else begin
          dph <= 1'b0;
          if (wr_q && !err_on) begin
            mem[a_q] <= hwdata[{a_q[1:0], 3'b000} +: 8];
          end
        end
      end else if (htrans == pdma_pkg::HTRANS_NONSEQ && hgrant) begin
        dph  <= 1'b1;
        a_q  <= haddr[7:0];
        wr_q <= hwrite;
        wcnt <= slow ? 2'h2 : 2'h0;
      end
    end
  end
endmodule

// ---- sim/test_peripheral_dma_channel.sv ----
/*
  Self-checking bench for one DMA channel: register port tasks, a
  peripheral stream driver and a RAM slave model on the bus side.
  Assumes the default channel parameters and RAM near the base address.
*/
module test_peripheral_dma_channel;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        irq;
  logic        hbusreq;
  logic        hgrant;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic [1:0]  hresp;
  logic [31:0] hrdata;
  logic        out_valid;
  logic [7:0]  out_data;
  logic        out_ready = 1'b0;
  logic        in_valid = 1'b0;
  logic [7:0]  in_data = 8'h00;
  logic        in_last = 1'b0;
  logic        in_ready;
  logic        busy;
  logic        slow = 1'b0;
  logic        err_on = 1'b0;
  integer      seed = 32'h6af9;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [31:0] aq[$];
  logic [7:0]  oq[$];
  logic [7:0]  wq[$];

  always #5 clk = ~clk;

  pdma_channel u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .hbusreq(hbusreq), .hgrant(hgrant), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hresp(hresp),
    .hrdata(hrdata), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .in_valid(in_valid), .in_data(in_data),
    .in_last(in_last), .in_ready(in_ready), .busy(busy));

  pdma_ram_model u_ram (.clk(clk), .rst_n(rst_n), .slow(slow), .err_on(err_on),
    .hbusreq(hbusreq), .hgrant(hgrant), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hresp(hresp),
    .hrdata(hrdata));

  task automatic end_of_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Bus monitor, random peripheral back-pressure and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (htrans == pdma_pkg::HTRANS_NONSEQ && hgrant && hready) aq.push_back(haddr);
    if (out_valid && out_ready) oq.push_back(out_data);
    out_ready <= ($random(seed) & 3) != 0;
    if (cyc == 50000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic go(input logic [31:0] cfg);
    wr(pdma_pkg::OFS_CONFIG, cfg);
    wr(pdma_pkg::OFS_TASK, 32'h1);
  endtask

  // Busy is sampled mid-cycle, clear of the edge that updates it
  task automatic wait_idle();
    @(negedge clk);
    while (busy !== 1'b0 && cyc < 49000) @(negedge clk);
    repeat (3) @(posedge clk);
  endtask

  task automatic irq_is(input logic b);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'(b));
  endtask

  // Holds each byte until the channel takes it
  task automatic feed(input int n, input bit last);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      wq.push_back(b);
      in_valid <= 1'b1;
      in_data <= b;
      in_last <= last && i == n - 1;
      do @(posedge clk); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
    in_last <= 1'b0;
  endtask

  initial begin
    logic [31:0] d;
    logic [31:0] p;
    logic [31:0] cnt;
    for (int i = 0; i < 256; i++) u_ram.mem[i] = 8'($random(seed));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(pdma_pkg::OFS_BUF_POINTER, d);
    chk(d, pdma_pkg::RST_BUF_POINTER);
    rd(8'h3c, d);
    chk(d, 32'h0);
    wr(pdma_pkg::OFS_TASK, 32'h1);
    wait_idle();
    chk(32'(aq.size()), 32'h0);
    wr(pdma_pkg::OFS_INTEN, 32'h7);
    for (int k = 0; k < 4; k++) begin
      slow <= k[0];
      cnt = (k == 0) ? 32'h1 : 32'h1 + ($random(seed) & 7);
      p = 32'h2000_0005 + 32'(k * 16);
      aq.delete();
      oq.delete();
      wr(pdma_pkg::OFS_BUF_POINTER, p);
      wr(pdma_pkg::OFS_MAX_COUNT, cnt);
      go(32'h0);
      wr(pdma_pkg::OFS_MAX_COUNT, 32'h1f);
      wait_idle();
      chk(32'(aq.size()), cnt);
      chk(32'(oq.size()), cnt);
      for (int i = 0; i < cnt; i++) begin
        chk(aq[i], p + 32'(i));
        chk(32'(oq[i]), 32'(u_ram.mem[p[7:0] + 8'(i)]));
      end
      rd(pdma_pkg::OFS_XFER_COUNT, d);
      chk(d, cnt);
      rd(pdma_pkg::OFS_STATUS, d);
      chk(d & 32'h7, 32'h1);
      chk(32'(irq), 32'h1);
      chk(32'(hsize), 32'(pdma_pkg::HSIZE_BYTE));
      wr(pdma_pkg::OFS_INTCLR, 32'h7);
    end
    slow <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      p = 32'h2000_0080 + 32'(k * 3);
      wq.delete();
      wr(pdma_pkg::OFS_BUF_POINTER, p);
      wr(pdma_pkg::OFS_MAX_COUNT, 32'h6);
      go(32'h1);
      feed(k ? 6 : 3, k == 0);
      wait_idle();
      rd(pdma_pkg::OFS_XFER_COUNT, d);
      chk(d, 32'(wq.size()));
      for (int i = 0; i < wq.size(); i++) chk(32'(u_ram.mem[p[7:0] + 8'(i)]), 32'(wq[i]));
    end
    aq.delete();
    wr(pdma_pkg::OFS_LIST, 32'h1);
    wr(pdma_pkg::OFS_BUF_POINTER, 32'h2000_0040);
    wr(pdma_pkg::OFS_MAX_COUNT, 32'h4);
    repeat (3) begin
      go(32'h0);
      wait_idle();
    end
    chk(32'(aq.size()), 32'd12);
    for (int i = 0; i < 12; i++) chk(aq[i], 32'h2000_0040 + 32'(i));
    rd(pdma_pkg::OFS_STATE, d);
    chk(32'(d[31:16]), 32'h3);
    wr(pdma_pkg::OFS_LIST, 32'h0);
    for (int k = 0; k < 3; k++) begin
      aq.delete();
      err_on <= k == 2;
      wr(pdma_pkg::OFS_INTCLR, 32'h7);
      wr(pdma_pkg::OFS_BUF_POINTER, k == 0 ? 32'h0000_1000 : (k == 1 ? 32'h2003_fffe : 32'h2000_0010));
      go(32'h0);
      wait_idle();
      chk(32'(aq.size()), k == 2 ? 32'h1 : 32'h0);
      rd(pdma_pkg::OFS_STATUS, d);
      chk(d & 32'h7, k == 2 ? 32'h3 : 32'h2);
    end
    err_on <= 1'b0;
    slow <= 1'b1;
    wr(pdma_pkg::OFS_INTCLR, 32'h7);
    wr(pdma_pkg::OFS_MAX_COUNT, 32'h20);
    go(32'h3);
    feed(8, 1'b0);
    wr(pdma_pkg::OFS_TASK, 32'h2);
    wait_idle();
    rd(pdma_pkg::OFS_STATUS, d);
    chk(d & 32'h4, 32'h4);
    wr(pdma_pkg::OFS_INTEN, 32'h0);
    irq_is(1'b0);
    wr(pdma_pkg::OFS_INTEN, 32'h4);
    irq_is(1'b1);
    wr(pdma_pkg::OFS_INTCLR, 32'h4);
    irq_is(1'b0);
    end_of_test();
  end
endmodule
